// ==== supervisor_pkg.sv ====
// constants, types and register map of the quad supply supervisor
// Notes on behaviour
// - reset output asserts while any channel is low or manual reset is held.
// - reset stays asserted one full timeout after all causes have cleared.
// - each channel output is low exactly while its own supply is low.
// - watchdog input stuck high or low past its timeout asserts reset.
// - watchdog timer clears on every input edge and while reset asserts.
// - after reset the watchdog allows 54 s for the first input edge.
// - floating watchdog input disables the watchdog; host must toggle it.
// - capacitor mode timeout is 2.06 megohm times the set capacitance.
// - supply-tied timeout select uses internal timeout of at least 140 ms.
// - margin input low forces the reset and channel outputs to their released high state.
// - tolerance input low selects 5 percent, high selects 10 percent.
package supervisor_pkg;

  localparam int unsigned CLK_HZ  = 10_000_000;
  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned NUM_CH  = 4;

  // timing figures in their own units and derived cycle counts
  localparam int unsigned RST_INT_MS    = 140;
  localparam int unsigned WD_TIMEOUT_MS = 1600;
  localparam int unsigned WD_STARTUP_S  = 54;
  localparam int unsigned CAP_RES_KOHM  = 2060;
  localparam logic [31:0] RST_INT_CYC_DFLT =
    32'((RST_INT_MS * (CLK_HZ / 1000)));
  localparam logic [31:0] WD_TIMEOUT_CYC_DFLT =
    32'((WD_TIMEOUT_MS * (CLK_HZ / 1000)));
  localparam logic [31:0] WD_STARTUP_CYC_DFLT =
    32'((WD_STARTUP_S * CLK_HZ));
  // cycles per picofarad times 1000
  localparam logic [31:0] CAP_MCYC_PER_PF = 32'((CAP_RES_KOHM * CLK_MHZ));
  localparam logic [31:0] MILLI           = 32'd1000;

  // register byte offsets
  localparam logic [7:0] OFS_STATUS    = 8'h00;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h04;
  localparam logic [7:0] OFS_INT_EN    = 8'h08;
  localparam logic [7:0] OFS_CAP_PF    = 8'h0c;
  localparam logic [7:0] OFS_LIVE      = 8'h10;

  // event bit positions in status, clear and enable
  localparam int unsigned EV_W      = 6;
  localparam int unsigned EV_RST    = 0;
  localparam int unsigned EV_WD     = 1;
  localparam int unsigned EV_CH_LO  = 2;

  // live register field positions
  localparam int unsigned LV_UV     = 0;
  localparam int unsigned LV_MAN_RST_N = 4;
  localparam int unsigned LV_FLOAT  = 5;
  localparam int unsigned LV_TSEL   = 6;
  localparam int unsigned LV_THRESH_SET = 7;
  localparam int unsigned LV_MARG_N = 8;
  localparam int unsigned LV_RST    = 9;
  localparam int unsigned LV_WD_SU  = 10;

  // reset values
  localparam logic [15:0]   CAP_PF_RST = 16'h0064;
  localparam logic [EV_W-1:0] INT_EN_RST = 6'h00;

  typedef struct packed {
    logic [3:0] uv;          // high while a supply is below threshold
    logic       manual_reset_n;
    logic       kick;
    logic       kick_float;  // watchdog input seen unconnected
    logic       tsel_vcc;    // timeout select tied to supply
    logic       tolerance_select;
    logic       margin_n;
  } pins_in_s;

  localparam pins_in_s PINS_RST = '{uv: 4'hf, manual_reset_n: 1'b1,
                                    kick: 1'b0, kick_float: 1'b1,
                                    tsel_vcc: 1'b1, tolerance_select: 1'b0,
                                    margin_n: 1'b1};

  typedef struct packed {
    logic       rst_o;
    logic       rst_oe;
    logic [3:0] chan_o;
    logic [3:0] chan_oe;
    logic       thresh_10pct;
  } pins_out_s;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } ahb_req_s;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } ahb_rsp_s;

  typedef enum logic [1:0] {SQ_HOLD, SQ_TIMEOUT, SQ_RUN} seq_e;
  typedef enum logic [1:0] {WD_OFF, WD_STARTUP, WD_RUN} wd_phase_e;

  // capacitance in pF to reset timeout cycles, rounded up, at least one
  function automatic logic [31:0] cap_to_cycles(input logic [15:0] pf);
    logic [31:0] p;
    logic [31:0] c;
    p = {16'h0000, pf} * CAP_MCYC_PER_PF;
    c = (p + MILLI - 32'd1) / MILLI;
    return (c == 32'd0) ? 32'd1 : c;
  endfunction : cap_to_cycles

endpackage : supervisor_pkg

// ==== pin_sync.sv ====
// three-stage synchroniser with agreement filter for the pin inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire supervisor_pkg::pins_in_s raw,
  output var  supervisor_pkg::pins_in_s clean
);

  typedef struct packed {
    supervisor_pkg::pins_in_s s1;
    supervisor_pkg::pins_in_s s2;
    supervisor_pkg::pins_in_s s3;
    supervisor_pkg::pins_in_s stable;
  } sync_st_s;

  sync_st_s st_q;
  sync_st_s st_d;

  // a bit changes only once stages two and three agree
  always_comb begin
    st_d        = st_q;
    st_d.s1     = raw;
    st_d.s2     = st_q.s1;
    st_d.s3     = st_q.s2;
    st_d.stable = (st_q.s2 & st_q.s3) |
                  (st_q.stable & (st_q.s2 ^ st_q.s3));
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= '{s1: supervisor_pkg::PINS_RST, s2: supervisor_pkg::PINS_RST,
                s3: supervisor_pkg::PINS_RST,
                stable: supervisor_pkg::PINS_RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign clean = st_q.stable;

endmodule : pin_sync
`default_nettype wire

// ==== kick_watchdog.sv ====
// watchdog timer with startup window and floating-input disable
`timescale 1ns/100ps
`default_nettype none
module kick_watchdog (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        kick,
  input  wire logic        kick_float,
  input  wire logic        reset_active,
  input  wire logic [31:0] timeout_cyc,
  input  wire logic [31:0] startup_cyc,
  output logic             bite,
  output logic             in_startup
);

  typedef struct packed {
    supervisor_pkg::wd_phase_e phase;
    logic [31:0]               cnt;
    logic                      kick_prev;
    logic                      bite;
  } wd_st_s;

  wd_st_s      st_q;
  wd_st_s      st_d;
  logic [31:0] limit;
  logic        edge_seen;

  assign limit     = (st_q.phase == supervisor_pkg::WD_STARTUP) ?
                     startup_cyc : timeout_cyc;
  assign edge_seen = kick ^ st_q.kick_prev;

  // count idle cycles, clear on edges and reset, bite at the limit
  always_comb begin
    st_d           = st_q;
    st_d.kick_prev = kick;
    st_d.bite      = 1'b0;
    if (kick_float) begin
      st_d.phase = supervisor_pkg::WD_OFF;
      st_d.cnt   = 32'd0;
    end else if (reset_active || st_q.phase == supervisor_pkg::WD_OFF) begin
      st_d.phase = supervisor_pkg::WD_STARTUP;
      st_d.cnt   = 32'd0;
    end else if (edge_seen) begin
      st_d.phase = supervisor_pkg::WD_RUN;
      st_d.cnt   = 32'd0;
    end else if (st_q.cnt >= limit - 32'd1) begin
      st_d.bite = 1'b1;
      st_d.cnt  = 32'd0;
    end else begin
      st_d.cnt = st_q.cnt + 32'd1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= '{phase: supervisor_pkg::WD_OFF, cnt: 32'd0,
                kick_prev: 1'b0, bite: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign bite       = st_q.bite;
  assign in_startup = (st_q.phase == supervisor_pkg::WD_STARTUP);

  AST_WD_EDGE_CLEARS: assert property (@(posedge core_clk) disable iff (reset)
    !kick_float && edge_seen |=> st_q.cnt == 32'd0 && !st_q.bite)
    else $error("watchdog count not cleared by input edge");

  AST_WD_RESET_CLEARS: assert property (@(posedge core_clk)
    disable iff (reset)
    reset_active && !kick_float |=>
      st_q.phase == supervisor_pkg::WD_STARTUP && st_q.cnt == 32'd0)
    else $error("watchdog not restarted while reset asserted");

  AST_WD_BITE_AT_LIMIT: assert property (@(posedge core_clk)
    disable iff (reset)
    st_q.bite |-> $past(st_q.cnt) >= $past(limit) - 32'd1 &&
                  !$past(edge_seen) && !$past(reset_active))
    else $error("watchdog bite before its limit");

  AST_WD_STARTUP_LIMIT: assert property (@(posedge core_clk)
    disable iff (reset)
    st_q.bite && $past(st_q.phase) == supervisor_pkg::WD_STARTUP |->
      $past(st_q.cnt) >= startup_cyc - 32'd1)
    else $error("startup window cut short");

  AST_WD_FLOAT_OFF: assert property (@(posedge core_clk) disable iff (reset)
    kick_float |=> !st_q.bite ##1 !st_q.bite)
    else $error("watchdog bit while input floating");

endmodule : kick_watchdog
`default_nettype wire

// ==== quad_supply_supervisor_watchdog.sv ====
// supervisor core: reset sequencer, pin outputs, interrupts, AHB-Lite slave
`timescale 1ns/100ps
`default_nettype none
module quad_supply_supervisor_watchdog #(
  parameter logic [31:0] RST_INT_CYC    = supervisor_pkg::RST_INT_CYC_DFLT,
  parameter logic [31:0] WD_TIMEOUT_CYC = supervisor_pkg::WD_TIMEOUT_CYC_DFLT,
  parameter logic [31:0] WD_STARTUP_CYC = supervisor_pkg::WD_STARTUP_CYC_DFLT
) (
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire supervisor_pkg::pins_in_s  pins_raw,
  output var  supervisor_pkg::pins_out_s pins_out,
  input  wire supervisor_pkg::ahb_req_s  ahb_req,
  output var  supervisor_pkg::ahb_rsp_s  ahb_rsp,
  output logic                           irq
);

  typedef struct packed {
    supervisor_pkg::seq_e          seq;
    logic [31:0]                   cnt;
    logic [3:0]                    uv_prev;
    logic [supervisor_pkg::EV_W-1:0] sts;
    logic [supervisor_pkg::EV_W-1:0] en;
    logic [15:0]                   cap;
    logic                          ap_valid;
    logic                          ap_write;
    logic [7:0]                    ap_addr;
    logic [31:0]                   rdata;
    logic                          irq;
    logic                          rst_oe;
    logic [3:0]                    chan_oe;
    logic                          thresh_10;
  } core_st_s;

  supervisor_pkg::pins_in_s pins;
  core_st_s                 st_q;
  core_st_s                 st_d;
  logic                     cause;
  logic                     reset_active;
  logic [31:0]              target;
  logic                     bite;
  logic                     wd_startup;
  logic [supervisor_pkg::EV_W-1:0] ev;
  logic [supervisor_pkg::EV_W-1:0] clr;
  logic                     take;
  logic [31:0]              live;

  // synchronise every pin-level input
  pin_sync u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .raw      (pins_raw),
    .clean    (pins)
  );

  // watchdog is held cleared while the sequencer asserts reset
  kick_watchdog u_wd (
    .core_clk     (core_clk),
    .reset        (reset),
    .kick         (pins.kick),
    .kick_float   (pins.kick_float),
    .reset_active (reset_active),
    .timeout_cyc  (WD_TIMEOUT_CYC),
    .startup_cyc  (WD_STARTUP_CYC),
    .bite         (bite),
    .in_startup   (wd_startup)
  );

  // reset causes and the timeout in force
  assign cause        = (|pins.uv) | ~pins.manual_reset_n;
  assign reset_active = (st_q.seq != supervisor_pkg::SQ_RUN);
  assign target       = pins.tsel_vcc ? RST_INT_CYC
                        : supervisor_pkg::cap_to_cycles(st_q.cap);
  assign take         = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];

  // live view of pins and sequencer state
  always_comb begin
    live = 32'h0000_0000;
    live[supervisor_pkg::LV_UV +: 4] = pins.uv;
    live[supervisor_pkg::LV_MAN_RST_N]  = pins.manual_reset_n;
    live[supervisor_pkg::LV_FLOAT]   = pins.kick_float;
    live[supervisor_pkg::LV_TSEL]    = pins.tsel_vcc;
    live[supervisor_pkg::LV_THRESH_SET] = pins.tolerance_select;
    live[supervisor_pkg::LV_MARG_N]  = pins.margin_n;
    live[supervisor_pkg::LV_RST]     = reset_active;
    live[supervisor_pkg::LV_WD_SU]   = wd_startup;
  end

  // sequencer, outputs, bus writes, events and read data
  always_comb begin
    st_d    = st_q;
    clr     = '0;
    ev      = '0;
    st_d.uv_prev = pins.uv;

    unique case (st_q.seq)
      supervisor_pkg::SQ_HOLD: begin
        st_d.cnt = 32'd0;
        if (!cause) begin
          st_d.seq = supervisor_pkg::SQ_TIMEOUT;
        end
      end
      supervisor_pkg::SQ_TIMEOUT: begin
        if (cause) begin
          st_d.seq = supervisor_pkg::SQ_HOLD;
          st_d.cnt = 32'd0;
        end else if (st_q.cnt >= target - 32'd1) begin
          st_d.seq = supervisor_pkg::SQ_RUN;
          st_d.cnt = 32'd0;
        end else begin
          st_d.cnt = st_q.cnt + 32'd1;
        end
      end
      supervisor_pkg::SQ_RUN: begin
        st_d.cnt = 32'd0;
        if (cause) begin
          st_d.seq = supervisor_pkg::SQ_HOLD;
        end else if (bite) begin
          st_d.seq = supervisor_pkg::SQ_TIMEOUT;
        end
      end
    endcase

    // open-drain pull-downs, all released during margin testing
    st_d.rst_oe  = (st_d.seq != supervisor_pkg::SQ_RUN) &
                   pins.margin_n;
    st_d.chan_oe = pins.uv & {4{pins.margin_n}};
    st_d.thresh_10 = pins.tolerance_select;

    // events for the sticky status
    ev[supervisor_pkg::EV_RST] = (st_q.seq == supervisor_pkg::SQ_RUN) &&
                                 (st_d.seq != supervisor_pkg::SQ_RUN);
    ev[supervisor_pkg::EV_WD]  = bite;
    ev[supervisor_pkg::EV_CH_LO +: 4] = pins.uv & ~st_q.uv_prev;

    // data phase of a write taken in the previous cycle
    if (st_q.ap_valid && st_q.ap_write) begin
      unique case (st_q.ap_addr)
        supervisor_pkg::OFS_INT_CLEAR: begin
          clr = ahb_req.hwdata[supervisor_pkg::EV_W-1:0];
        end
        supervisor_pkg::OFS_INT_EN: begin
          st_d.en = ahb_req.hwdata[supervisor_pkg::EV_W-1:0];
        end
        supervisor_pkg::OFS_CAP_PF: begin
          st_d.cap = ahb_req.hwdata[15:0];
        end
        default: begin
        end
      endcase
    end

    // a new event wins over a clear in the same cycle
    st_d.sts = (st_q.sts & ~clr) | ev;
    st_d.irq = |(st_d.sts & st_d.en);

    // address phase; read data built from the updated values
    st_d.ap_valid = take;
    st_d.ap_write = ahb_req.hwrite;
    st_d.ap_addr  = ahb_req.haddr[7:0];
    if (take && !ahb_req.hwrite) begin
      unique case (ahb_req.haddr[7:0])
        supervisor_pkg::OFS_STATUS: begin
          st_d.rdata = {26'h0, st_d.sts};
        end
        supervisor_pkg::OFS_INT_EN: begin
          st_d.rdata = {26'h0, st_d.en};
        end
        supervisor_pkg::OFS_CAP_PF: begin
          st_d.rdata = {16'h0000, st_d.cap};
        end
        supervisor_pkg::OFS_LIVE: begin
          st_d.rdata = live;
        end
        default: begin
          st_d.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= '{seq: supervisor_pkg::SQ_HOLD, cnt: 32'd0, uv_prev: 4'hf,
                sts: '0, en: supervisor_pkg::INT_EN_RST,
                cap: supervisor_pkg::CAP_PF_RST, ap_valid: 1'b0,
                ap_write: 1'b0, ap_addr: 8'h00, rdata: 32'h0000_0000,
                irq: 1'b0, rst_oe: 1'b1, chan_oe: 4'h0, thresh_10: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // pins drive low only when enabled; bus never waits
  always_comb begin
    pins_out.rst_o     = 1'b0;
    pins_out.rst_oe    = st_q.rst_oe;
    pins_out.chan_o    = 4'h0;
    pins_out.chan_oe   = st_q.chan_oe;
    pins_out.thresh_10pct = st_q.thresh_10;
    ahb_rsp.hrdata     = st_q.rdata;
    ahb_rsp.hreadyout  = 1'b1;
    ahb_rsp.hresp      = 1'b0;
  end

  assign irq = st_q.irq;

  AST_CAUSE_ASSERTS_RESET: assert property (@(posedge core_clk)
    disable iff (reset)
    cause && pins.margin_n |=> st_q.rst_oe ##1 reset_active)
    else $error("reset not asserted while a cause is active");

  AST_RELEASE_AFTER_TIMEOUT: assert property (@(posedge core_clk)
    disable iff (reset)
    $fell(reset_active) |->
      $past(st_q.seq) == supervisor_pkg::SQ_TIMEOUT &&
      $past(st_q.cnt) >= $past(target) - 32'd1 && !$past(cause))
    else $error("reset released before full timeout");

  AST_INTERNAL_TIMEOUT: assert property (@(posedge core_clk)
    disable iff (reset)
    $fell(reset_active) && $past(pins.tsel_vcc) |->
      $past(st_q.cnt) == RST_INT_CYC - 32'd1)
    else $error("internal timeout length wrong");

  AST_CAP_TIMEOUT: assert property (@(posedge core_clk) disable iff (reset)
    $fell(reset_active) && !$past(pins.tsel_vcc) |->
      $past(st_q.cnt) ==
        supervisor_pkg::cap_to_cycles($past(st_q.cap)) - 32'd1)
    else $error("capacitor timeout length wrong");

  AST_CHANNEL_FOLLOWS: assert property (@(posedge core_clk)
    disable iff (reset)
    pins.uv[0] && pins.margin_n ##1 pins.uv[0] |-> pins_out.chan_oe[0] &&
      (st_q.rst_oe || !$past(pins.margin_n)))
    else $error("channel output not low for low supply");

  AST_BITE_TO_TIMEOUT: assert property (@(posedge core_clk)
    disable iff (reset)
    bite && st_q.seq == supervisor_pkg::SQ_RUN && !cause |=>
      st_q.seq == supervisor_pkg::SQ_TIMEOUT && st_q.cnt == 32'd0)
    else $error("watchdog bite did not start a reset timeout");

  AST_MARGIN_RELEASES: assert property (@(posedge core_clk)
    disable iff (reset)
    !pins.margin_n |=> !pins_out.rst_oe && pins_out.chan_oe == 4'h0)
    else $error("outputs pulled low during margin");

  AST_TOLERANCE: assert property (@(posedge core_clk)
    disable iff (reset)
    $changed(pins.tolerance_select) |=>
      pins_out.thresh_10pct == $past(pins.tolerance_select))
    else $error("tolerance select not followed");

  AST_STICKY_SET_WINS: assert property (@(posedge core_clk)
    disable iff (reset)
    ev[supervisor_pkg::EV_WD] |=> st_q.sts[supervisor_pkg::EV_WD])
    else $error("watchdog event lost from status");

  AST_IRQ_LEVEL: assert property (@(posedge core_clk) disable iff (reset)
    irq == |(st_q.sts & st_q.en))
    else $error("interrupt level does not match status and enable");

  // further checks on the sequencer, a channel output, the watchdog, the sticky status and the bus
  AST_HOLD_WHILE_CAUSE: assert property (@(posedge core_clk)
    disable iff (reset)
    cause |=> st_q.seq == supervisor_pkg::SQ_HOLD)
    else $error("sequencer left hold while a cause is active");

  AST_TIMEOUT_COUNTS: assert property (@(posedge core_clk)
    disable iff (reset)
    st_q.seq == supervisor_pkg::SQ_TIMEOUT && !cause &&
      st_q.cnt < target - 32'd1 |=>
      st_q.seq == supervisor_pkg::SQ_TIMEOUT &&
      st_q.cnt == $past(st_q.cnt) + 32'd1)
    else $error("reset timeout count skipped or stopped");

  AST_CHANNEL_RELEASE: assert property (@(posedge core_clk)
    disable iff (reset)
    !pins.uv[1] |=> !pins_out.chan_oe[1])
    else $error("channel output low for a good supply");

  AST_NO_BITE_IN_RESET: assert property (@(posedge core_clk)
    disable iff (reset)
    reset_active |=> !bite)
    else $error("watchdog bite while reset asserted");

  AST_RESET_EVENT: assert property (@(posedge core_clk)
    disable iff (reset)
    st_q.seq == supervisor_pkg::SQ_RUN && cause |=>
      st_q.sts[supervisor_pkg::EV_RST])
    else $error("reset entry not recorded in status");

  AST_STICKY_CLEAR: assert property (@(posedge core_clk)
    disable iff (reset)
    st_q.ap_valid && st_q.ap_write &&
      st_q.ap_addr == supervisor_pkg::OFS_INT_CLEAR &&
      ahb_req.hwdata[supervisor_pkg::EV_WD] && !ev[supervisor_pkg::EV_WD] |=>
      !st_q.sts[supervisor_pkg::EV_WD])
    else $error("status bit not cleared by write");

  AST_RDATA_HOLDS: assert property (@(posedge core_clk)
    disable iff (reset)
    !take |=> $stable(ahb_rsp.hrdata))
    else $error("read data changed without a read");

endmodule : quad_supply_supervisor_watchdog
`default_nettype wire

// ==== host_model.sv ====
// processor model that services the watchdog input
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       rst_seen,
  input  wire logic       enable,
  input  wire logic [7:0] period,
  output logic            kick
);
  logic [7:0] cnt_q;

  // toggle the kick line every period cycles while running
  always_ff @(posedge core_clk) begin
    if (reset || rst_seen || !enable) begin
      cnt_q <= 8'h00;
    end else if (cnt_q == period - 8'h01) begin
      cnt_q <= 8'h00;
      kick  <= ~kick;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
    if (reset) begin
      kick <= 1'b0;
    end
  end
endmodule : host_model
`default_nettype wire

// ==== test_quad_supply_supervisor_watchdog.sv ====
// self-checking bench for the quad supply supervisor
`timescale 1ns/100ps
`default_nettype none
module test_quad_supply_supervisor_watchdog;
  localparam int RST_CYC = 20;
  localparam int WD_CYC  = 30;
  localparam int SU_CYC  = 60;

  logic                      core_clk;
  logic                      reset;
  supervisor_pkg::pins_in_s  pin_q;
  supervisor_pkg::pins_in_s  pins_raw;
  supervisor_pkg::pins_out_s pins_out;
  supervisor_pkg::ahb_req_s  req_q;
  supervisor_pkg::ahb_req_s  ahb_req;
  supervisor_pkg::ahb_rsp_s  ahb_rsp;
  logic                      irq;
  logic                      kick;
  logic                      host_en;
  logic [31:0]               seed = 32'hcd0c6554;
  logic [31:0]               rd;
  logic [3:0]                v;
  int                        error_cnt = 0;
  int                        tests_run = 0;
  int                        cyc = 0;
  int                        n;

  quad_supply_supervisor_watchdog #(
    .RST_INT_CYC    (32'(RST_CYC)),
    .WD_TIMEOUT_CYC (32'(WD_CYC)),
    .WD_STARTUP_CYC (32'(SU_CYC))
  ) dut_u (
    .core_clk (core_clk),
    .reset    (reset),
    .pins_raw (pins_raw),
    .pins_out (pins_out),
    .ahb_req  (ahb_req),
    .ahb_rsp  (ahb_rsp),
    .irq      (irq)
  );

  host_model host_u (
    .core_clk (core_clk),
    .reset    (reset),
    .rst_seen (pins_out.rst_oe),
    .enable   (host_en),
    .period   (8'd10),
    .kick     (kick)
  );

  // clock source
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // merge host kick and slave ready into the design inputs
  always_comb begin
    pins_raw       = pin_q;
    pins_raw.kick  = kick;
    ahb_req        = req_q;
    ahb_req.hready = ahb_rsp.hreadyout;
  end

  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // expected reset timeout in cycles
  function automatic int exp_cyc(input logic tsel, input int pf);
    int c;
    c = (pf * 20600 + 999) / 1000;
    return tsel ? RST_CYC : ((c < 1) ? 1 : c);
  endfunction : exp_cyc

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one single-word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge core_clk);
    req_q.hsel   <= 1'b1;
    req_q.htrans <= 2'b10;
    req_q.haddr  <= {24'h000000, a};
    req_q.hwrite <= wr;
    req_q.hsize  <= 3'h2;
    do @(posedge core_clk); while (ahb_rsp.hreadyout !== 1'b1);
    req_q.htrans <= 2'b00;
    req_q.hsel   <= 1'b0;
    req_q.hwdata <= wd;
    do @(posedge core_clk); while (ahb_rsp.hreadyout !== 1'b1);
    rdv = ahb_rsp.hrdata;
  endtask : bus

  // cycles until the reset output reaches a level
  task automatic wait_rst(input logic lvl, input int hi, output int cnt);
    cnt = 0;
    while (pins_out.rst_oe !== lvl && cnt <= hi) begin
      tick(1);
      cnt++;
    end
  endtask : wait_rst

  task automatic complete_run();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  // main sequence
  initial begin
    pin_q = '{uv: 4'hf, manual_reset_n: 1'b1, kick: 1'b0,
              kick_float: 1'b1, tsel_vcc: 1'b1, tolerance_select: 1'b0,
              margin_n: 1'b1};
    req_q   = '0;
    reset   = 1'b1;
    host_en = 1'b0;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    tick(2);
    check(32'(pins_out.rst_oe), 32'h1);
    check(32'({pins_out.rst_o, pins_out.chan_o}), 32'h0);
    check(32'(ahb_rsp.hresp), 32'h0);
    bus(1'b0, supervisor_pkg::OFS_CAP_PF, 32'h0, rd);
    check(rd, 32'h64);
    bus(1'b0, 8'h20, 32'h0, rd);
    check(rd, 32'h0);
    // random channel patterns, all supplies low first, supply 1 alone low last
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? 4'hf : (i == 11) ? 4'h2 : 4'(rnd() % 32'd15 + 32'd1);
      @(posedge core_clk);
      pin_q.uv <= v;
      tick(7);
      check(32'(pins_out.chan_oe), 32'(v));
      check(32'(pins_out.rst_oe), 32'(|v));
    end
    @(posedge core_clk);
    pin_q.uv <= 4'h0;
    wait_rst(1'b0, 400, n);
    check(32'(n >= RST_CYC + 2 && n <= RST_CYC + 9), 32'h1);
    // capacitor mode timeout after a manual reset
    bus(1'b1, supervisor_pkg::OFS_CAP_PF, 32'h5, rd);
    @(posedge core_clk);
    pin_q.tsel_vcc <= 1'b0;
    pin_q.manual_reset_n <= 1'b0;
    tick(7);
    check(32'(pins_out.rst_oe), 32'h1);
    @(posedge core_clk);
    pin_q.manual_reset_n <= 1'b1;
    wait_rst(1'b0, 400, n);
    check(32'(n >= exp_cyc(1'b0, 5) + 2 &&
              n <= exp_cyc(1'b0, 5) + 9), 32'h1);
    @(posedge core_clk);
    pin_q.tsel_vcc <= 1'b1;
    for (int t = 0; t < 2; t++) begin
      @(posedge core_clk);
      pin_q.tolerance_select <= t[0];
      tick(7);
      check(32'(pins_out.thresh_10pct), 32'(t[0]));
    end
    // margin masks the reset output and every channel output
    @(posedge core_clk);
    pin_q.uv       <= 4'hf;
    pin_q.margin_n <= 1'b0;
    tick(8);
    check(32'(pins_out.chan_oe), 32'h0);
    check(32'(pins_out.rst_oe), 32'h0);
    @(posedge core_clk);
    pin_q.margin_n <= 1'b1;
    tick(7);
    check(32'(pins_out.chan_oe), 32'hf);
    check(32'(pins_out.rst_oe), 32'h1);
    @(posedge core_clk);
    pin_q.uv <= 4'h0;
    wait_rst(1'b0, 400, n);
    // interrupt raise, mask and clear on channel events
    bus(1'b1, supervisor_pkg::OFS_INT_CLEAR, 32'h3f, rd);
    bus(1'b1, supervisor_pkg::OFS_INT_EN, 32'h04, rd);
    tick(2);
    check(32'(irq), 32'h0);
    @(posedge core_clk);
    pin_q.uv <= 4'h1;
    tick(7);
    check(32'(irq), 32'h1);
    @(posedge core_clk);
    pin_q.uv <= 4'h2;
    tick(7);
    bus(1'b0, supervisor_pkg::OFS_STATUS, 32'h0, rd);
    check(rd & 32'h0c, 32'h0c);
    bus(1'b1, supervisor_pkg::OFS_INT_CLEAR, 32'h04, rd);
    tick(2);
    check(32'(irq), 32'h0);
    bus(1'b0, supervisor_pkg::OFS_INT_CLEAR, 32'h0, rd);
    check(rd, 32'h0);
    // watchdog startup window, bite, service and stall
    @(posedge core_clk);
    pin_q.uv         <= 4'h0;
    pin_q.kick_float <= 1'b0;
    wait_rst(1'b0, 400, n);
    wait_rst(1'b1, 200, n);
    check(32'(n >= SU_CYC - 4 && n <= SU_CYC + 8), 32'h1);
    wait_rst(1'b0, 200, n);
    check(32'(n >= RST_CYC - 1 && n <= RST_CYC + 5), 32'h1);
    @(posedge core_clk);
    host_en <= 1'b1;
    wait_rst(1'b1, 200, n);
    check(32'(n > 200), 32'h1);
    @(posedge core_clk);
    host_en <= 1'b0;
    wait_rst(1'b1, 200, n);
    check(32'(n >= WD_CYC - 12 && n <= WD_CYC + 8), 32'h1);
    @(posedge core_clk);
    pin_q.kick_float <= 1'b1;
    wait_rst(1'b0, 200, n);
    wait_rst(1'b1, 200, n);
    check(32'(n > 200), 32'h1);
    bus(1'b0, supervisor_pkg::OFS_STATUS, 32'h0, rd);
    check(rd, 32'h0000_000b);
    bus(1'b0, supervisor_pkg::OFS_LIVE, 32'h0, rd);
    check(rd, 32'h0000_01f0);
    complete_run();
  end
endmodule : test_quad_supply_supervisor_watchdog
`default_nettype wire
